// *** rwic_pkg.sv ***
// Register map, field positions, reset values and types of the
// reset, wake and interrupt block. Assumes a 32-bit classic bus with
// one byte-wide register per word.
package rwic_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CORE_STATUS = 8'h03;
	localparam logic [7:0] IDX_IRQ_CTRL = 8'h0b;
	localparam logic [7:0] IDX_PFLAGS = 8'h0c;
	localparam logic [7:0] IDX_CMP_CTRL = 8'h19;
	localparam logic [7:0] IDX_RESULT_HI = 8'h1e;
	localparam logic [7:0] IDX_ADC_MAIN = 8'h1f;
	localparam logic [7:0] IDX_OPTION = 8'h81;
	localparam logic [7:0] IDX_PEN = 8'h8c;
	localparam logic [7:0] IDX_RST_CAUSE = 8'h8e;
	localparam logic [7:0] IDX_ANALOG_SEL = 8'h91;
	localparam logic [7:0] IDX_CHG_EN = 8'h96;
	localparam logic [7:0] IDX_VREF_CTRL = 8'h99;
	localparam logic [7:0] IDX_RESULT_LO = 8'h9e;
	localparam logic [7:0] IDX_ADC_CLK = 8'h9f;
	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_OPTION = 8'hff;
	localparam logic [7:0] RST_ANALOG_SEL = 8'hff;
	// Implemented bits
	localparam logic [7:0] MASK_PFLAGS = 8'hc9;
	localparam logic [7:0] MASK_CMP = 8'h5f;
	localparam logic [7:0] MASK_VREF = 8'haf;
	localparam logic [7:0] MASK_ADC_MAIN = 8'hdf;
	localparam logic [7:0] MASK_ADC_CLK = 8'h70;
	localparam logic [7:0] MASK_CHG_EN = 8'h3f;
	// Field positions
	localparam int B_GLOBAL_EN = 7;
	localparam int B_PERIPH_EN = 6;
	localparam int B_EXT_FLAG = 1;
	localparam int PF_EE = 7;
	localparam int PF_AD = 6;
	localparam int PF_CMP = 3;
	localparam int PF_TMR1 = 0;
	localparam int B_VREF_EN = 7;
	localparam int B_GO = 1;
	localparam int B_ADC_ON = 0;
	localparam int B_EDGE_SEL = 6;
	localparam int B_NO_TIMEOUT = 4;
	localparam int B_NO_SLEEP = 3;
	localparam int ADCS_LSB = 4;
	localparam logic [2:0] CM_OFF = 3'b111;
	localparam logic [1:0] ADCS_RC = 2'b11;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	// One instruction of start delay on the RC clock
	localparam int CLK_NS = 50;
	localparam int RC_WAIT_NS = 50;
	localparam int RC_WAIT_CYC = (RC_WAIT_NS + CLK_NS - 1) / CLK_NS;
	typedef struct packed {
		logic ee_done;
		logic cmp_change;
		logic tmr1_roll;
		logic timer0_count_roll;
	} rwic_evt_t;
	typedef enum logic [1:0] {
		S_AWAKE = 2'b01,
		S_ASLEEP = 2'b10
	} rwic_pwr_t;
	typedef enum logic [2:0] {
		A_IDLE = 3'b001,
		A_WAIT = 3'b010,
		A_CONV = 3'b100
	} rwic_adc_t;
endpackage

// *** rwic_pin_events.sv ***
// Edge detector for the external interrupt pin and mismatch detector
// for the port pins. Pins are synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module rwic_pin_events (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins and setup
	input wire logic ext_pin_i,
	input wire logic edge_rising_i,
	input wire logic [5:0] porta_i,
	input wire logic [5:0] chg_en_i,
	input wire logic port_read_i,
	// Events
	output logic ext_edge_o,
	output logic port_chg_o
);
	logic pin_prev;
	logic [5:0] port_snap;
	wire rise = ext_pin_i & ~pin_prev;
	wire fall = ~ext_pin_i & pin_prev;
	wire mismatch = |((porta_i ^ port_snap) & chg_en_i);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Start from the pin levels so a release makes no false edge
			pin_prev <= ext_pin_i;
			port_snap <= porta_i;
			ext_edge_o <= 1'b0;
			port_chg_o <= 1'b0;
		end else begin
			pin_prev <= ext_pin_i;
			ext_edge_o <= edge_rising_i ? rise : fall;
			// Snapshot refreshes on a read; a change in that cycle is lost
			if (port_read_i)
				port_snap <= porta_i;
			port_chg_o <= mismatch & ~port_read_i;
		end
	end
endmodule
`default_nettype wire

// *** rwic_ctrl.sv ***
// Reset, wake-up and interrupt control with its register file.
// Assumes a classic Wishbone master, peripherals that pulse their
// events for one cycle and a core that runs on clk_i.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module rwic_ctrl (
	// Clock and power-on reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [9:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Other reset sources and watchdog
	input wire logic ext_rst_i,
	input wire logic wdt_rst_i,
	input wire logic wdt_wake_i,
	input wire logic bod_i,
	// Core
	input wire logic sleep_exec_i,
	input wire logic data_protect_cfg_i,
	output logic irq_o,
	output logic wake_o,
	output logic asleep_o,
	output logic pc_load_o,
	output logic [12:0] pc_vector_o,
	output logic wdt_clear_o,
	output logic ee_protect_o,
	// Pins and peripherals
	input wire logic ext_irq_pin_i,
	input wire logic [5:0] porta_i,
	input wire logic port_read_i,
	input wire rwic_pkg::rwic_evt_t evt_i,
	input wire logic adc_done_i,
	input wire logic [9:0] adc_result_i,
	output logic [5:0] porta_dig_o,
	output logic cmp_on_o,
	output logic [2:0] cmp_mode_o,
	output logic vref_on_o,
	output logic adc_power_o,
	output logic adc_start_o,
	output logic adc_abort_o
);
	logic [7:0] irq_ctrl, pflags, pen, cmp_ctrl, vref_ctrl;
	logic [7:0] adc_main, adc_clk, option_cfg, analog_sel, chg_en;
	logic [7:0] result_hi, result_lo;
	logic no_por, no_bod, no_sleep, no_timeout, adc_pwr_down;
	logic [3:0] wait_cnt;
	rwic_pkg::rwic_pwr_t pwr_state;
	rwic_pkg::rwic_adc_t adc_state;
	logic ext_edge, port_chg;

	// Bus decode; writes land on the edge that sees ack high
	wire [7:0] idx = adr_i[9:2];
	wire [7:0] wr_byte = dat_i[7:0];
	wire wr_go = cyc_i & stb_i & we_i & ack_o & sel_i[0];
	wire rd_go = cyc_i & stb_i & ~ack_o;

	function automatic logic wr_hit(input logic [7:0] target);
		return wr_go && (idx == target);
	endfunction

	function automatic logic is_rc(input logic [7:0] clk_sel);
		return clk_sel[rwic_pkg::ADCS_LSB +: 2] == rwic_pkg::ADCS_RC;
	endfunction

	// Any reset reinitialises; a watchdog wake is not a reset
	wire dev_rst = rst_i | ext_rst_i | wdt_rst_i | bod_i;
	wire glb_en = irq_ctrl[rwic_pkg::B_GLOBAL_EN];
	wire asleep = pwr_state == rwic_pkg::S_ASLEEP;
	wire cmp_active = cmp_ctrl[2:0] != rwic_pkg::CM_OFF;
	wire rc_clk = is_rc(adc_clk);

	// Event detection
	rwic_pin_events u_pins (
		.clk_i(clk_i),
		.rst_i(dev_rst),
		.ext_pin_i(ext_irq_pin_i),
		.edge_rising_i(option_cfg[rwic_pkg::B_EDGE_SEL]),
		.porta_i(porta_i),
		.chg_en_i(chg_en[5:0]),
		.port_read_i(port_read_i),
		.ext_edge_o(ext_edge),
		.port_chg_o(port_chg)
	);

	// Conversion sequencing
	wire go_set = wr_hit(rwic_pkg::IDX_ADC_MAIN) & wr_byte[rwic_pkg::B_GO]
		& wr_byte[rwic_pkg::B_ADC_ON] & (adc_state == rwic_pkg::A_IDLE);
	wire wait_done = wait_cnt == 4'(rwic_pkg::RC_WAIT_CYC - 1);
	wire in_conv = adc_state == rwic_pkg::A_CONV;
	wire conv_done = in_conv & adc_done_i;
	wire sleep_abort = in_conv & sleep_exec_i & ~rc_clk & ~asleep;
	wire busy = adc_state != rwic_pkg::A_IDLE;
	wire adc_end = conv_done | sleep_abort;

	// Flag sets; a set beats a software clear in the same cycle
	wire [7:0] irq_set = {5'h00, evt_i.timer0_count_roll, ext_edge, port_chg};
	wire cmp_evt = evt_i.cmp_change & cmp_active;
	wire [7:0] pf_set = {evt_i.ee_done, conv_done, 2'b00, cmp_evt,
		2'b00, evt_i.tmr1_roll};
	wire [7:0] next_irq_ctrl = (wr_hit(rwic_pkg::IDX_IRQ_CTRL) ? wr_byte
		: irq_ctrl) | irq_set;
	wire [7:0] next_pflags = ((wr_hit(rwic_pkg::IDX_PFLAGS) ? wr_byte
		: pflags) | pf_set) & rwic_pkg::MASK_PFLAGS;
	wire [7:0] adc_wr = wr_hit(rwic_pkg::IDX_ADC_MAIN) ?
		(wr_byte & rwic_pkg::MASK_ADC_MAIN) : adc_main;
	// Completion or abort drops go but never the converter-on bit
	wire [7:0] next_adc_main = adc_end ?
		(adc_wr & ~(8'h01 << rwic_pkg::B_GO)) : adc_wr;

	// Pending sources; wake ignores the global enable
	wire periph_pend = irq_ctrl[rwic_pkg::B_PERIPH_EN] & |(pflags & pen);
	wire core_pend = |(irq_ctrl[5:3] & irq_ctrl[2:0]);
	wire src_pend = core_pend | periph_pend;
	wire irq_wake = asleep & src_pend;
	wire wake_now = irq_wake | (asleep & wdt_wake_i);
	wire [5:0] ana_mask = analog_sel[5:0] | {4'h0, {2{cmp_active}}};

	// Read selection; unmapped indices read zero
	function automatic logic [7:0] rd_mux(input logic [7:0] i);
		case (i)
			rwic_pkg::IDX_CORE_STATUS:
				return {3'b000, no_timeout, no_sleep, 3'b000};
			rwic_pkg::IDX_IRQ_CTRL: return irq_ctrl;
			rwic_pkg::IDX_PFLAGS: return pflags;
			rwic_pkg::IDX_CMP_CTRL: return cmp_ctrl;
			rwic_pkg::IDX_RESULT_HI: return result_hi;
			rwic_pkg::IDX_ADC_MAIN: return adc_main;
			rwic_pkg::IDX_OPTION: return option_cfg;
			rwic_pkg::IDX_PEN: return pen;
			rwic_pkg::IDX_RST_CAUSE: return {6'h00, no_por, no_bod};
			rwic_pkg::IDX_ANALOG_SEL: return analog_sel;
			rwic_pkg::IDX_CHG_EN: return chg_en;
			rwic_pkg::IDX_VREF_CTRL: return vref_ctrl;
			rwic_pkg::IDX_RESULT_LO: return result_lo;
			rwic_pkg::IDX_ADC_CLK: return adc_clk;
			default: return 8'h00;
		endcase
	endfunction

	// Bus answer, one wait state
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			if (rd_go)
				dat_o <= {24'h00_0000, rd_mux(idx)};
		end
	end

	// Interrupt control keeps its port change flag over non-POR resets
	always_ff @(posedge clk_i) begin
		if (dev_rst)
			irq_ctrl <= {7'h00, ~rst_i & irq_ctrl[0]};
		else
			irq_ctrl <= next_irq_ctrl;
	end

	// Comparator and reference setup; sleep leaves them alone
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			cmp_ctrl <= rwic_pkg::RST_ZERO;
			vref_ctrl <= rwic_pkg::RST_ZERO;
		end else begin
			if (wr_hit(rwic_pkg::IDX_CMP_CTRL))
				cmp_ctrl <= wr_byte & rwic_pkg::MASK_CMP;
			if (wr_hit(rwic_pkg::IDX_VREF_CTRL))
				vref_ctrl <= wr_byte & rwic_pkg::MASK_VREF;
		end
	end

	// Plain setup registers
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			pflags <= rwic_pkg::RST_ZERO;
			pen <= rwic_pkg::RST_ZERO;
			option_cfg <= rwic_pkg::RST_OPTION;
			analog_sel <= rwic_pkg::RST_ANALOG_SEL;
			chg_en <= rwic_pkg::RST_ZERO;
			adc_clk <= rwic_pkg::RST_ZERO;
		end else begin
			pflags <= next_pflags;
			if (wr_hit(rwic_pkg::IDX_PEN))
				pen <= wr_byte & rwic_pkg::MASK_PFLAGS;
			if (wr_hit(rwic_pkg::IDX_OPTION))
				option_cfg <= wr_byte;
			if (wr_hit(rwic_pkg::IDX_ANALOG_SEL))
				analog_sel <= wr_byte;
			if (wr_hit(rwic_pkg::IDX_CHG_EN))
				chg_en <= wr_byte & rwic_pkg::MASK_CHG_EN;
			if (wr_hit(rwic_pkg::IDX_ADC_CLK))
				adc_clk <= wr_byte & rwic_pkg::MASK_ADC_CLK;
		end
	end

	// Result pair has no reset: it survives every reset
	always_ff @(posedge clk_i) begin
		if (conv_done & ~dev_rst) begin
			result_hi <= {6'h00, adc_result_i[9:8]};
			result_lo <= adc_result_i[7:0];
		end
	end

	// Reset cause: power-on bit cleared by power-on, brown-out bit
	// by brown-out only; no value of its own at power-on
	always_ff @(posedge clk_i) begin
		if (rst_i)
			no_por <= 1'b0;
		else if (wr_hit(rwic_pkg::IDX_RST_CAUSE))
			no_por <= wr_byte[1];
	end

	always_ff @(posedge clk_i) begin
		if (bod_i)
			no_bod <= 1'b0;
		else if (wr_hit(rwic_pkg::IDX_RST_CAUSE))
			no_bod <= wr_byte[0];
	end

	// Sleep state and status bits
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			pwr_state <= rwic_pkg::S_AWAKE;
			no_sleep <= 1'b1;
			no_timeout <= ~wdt_rst_i | rst_i;
		end else begin
			unique case (pwr_state)
				rwic_pkg::S_AWAKE: begin
					if (sleep_exec_i) begin
						pwr_state <= rwic_pkg::S_ASLEEP;
						no_sleep <= 1'b0;
						no_timeout <= 1'b1;
					end
				end
				rwic_pkg::S_ASLEEP: begin
					if (wake_now)
						pwr_state <= rwic_pkg::S_AWAKE;
					if (wake_now & ~irq_wake)
						no_timeout <= 1'b0;
				end
			endcase
		end
	end

	// Converter state
	always_ff @(posedge clk_i) begin
		if (dev_rst) begin
			adc_state <= rwic_pkg::A_IDLE;
			adc_main <= rwic_pkg::RST_ZERO;
			wait_cnt <= 4'h0;
			adc_pwr_down <= 1'b0;
		end else begin
			adc_main <= next_adc_main;
			if (wake_now | wr_hit(rwic_pkg::IDX_ADC_MAIN))
				adc_pwr_down <= 1'b0;
			else if (sleep_abort)
				adc_pwr_down <= 1'b1;
			else if (conv_done & asleep & ~pen[rwic_pkg::PF_AD])
				adc_pwr_down <= 1'b1;
			unique case (adc_state)
				rwic_pkg::A_IDLE: begin
					wait_cnt <= 4'h0;
					if (go_set)
						adc_state <= rc_clk ? rwic_pkg::A_WAIT
							: rwic_pkg::A_CONV;
				end
				rwic_pkg::A_WAIT: begin
					wait_cnt <= wait_cnt + 4'h1;
					if (wait_done)
						adc_state <= rwic_pkg::A_CONV;
				end
				rwic_pkg::A_CONV: begin
					if (adc_end)
						adc_state <= rwic_pkg::A_IDLE;
				end
			endcase
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			wake_o <= 1'b0;
			asleep_o <= 1'b0;
			pc_load_o <= 1'b0;
			pc_vector_o <= rwic_pkg::IRQ_VECTOR;
			wdt_clear_o <= 1'b0;
			ee_protect_o <= 1'b0;
			porta_dig_o <= 6'h00;
			cmp_on_o <= 1'b0;
			cmp_mode_o <= 3'b000;
			vref_on_o <= 1'b0;
			adc_power_o <= 1'b0;
			adc_start_o <= 1'b0;
			adc_abort_o <= 1'b0;
		end else begin
			irq_o <= glb_en & src_pend & ~dev_rst;
			wake_o <= wake_now & ~dev_rst;
			asleep_o <= asleep;
			pc_load_o <= irq_wake & glb_en & ~dev_rst;
			pc_vector_o <= rwic_pkg::IRQ_VECTOR;
			wdt_clear_o <= wake_now & ~dev_rst;
			// Protection only hides data from outside; core access stays
			ee_protect_o <= ~data_protect_cfg_i;
			porta_dig_o <= porta_i & ~ana_mask;
			cmp_on_o <= cmp_active;
			cmp_mode_o <= cmp_ctrl[2:0];
			vref_on_o <= vref_ctrl[rwic_pkg::B_VREF_EN];
			adc_power_o <= adc_main[rwic_pkg::B_ADC_ON] & ~adc_pwr_down;
			adc_start_o <= ~dev_rst & ((adc_state == rwic_pkg::A_WAIT
				&& wait_done) || (go_set && !rc_clk));
			adc_abort_o <= (dev_rst & busy) | sleep_abort;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_go_rc;
		go_set && rc_clk && !dev_rst;
	endsequence

	sequence s_start_late;
		!adc_start_o ##1 adc_start_o;
	endsequence

	a_vector_on_wake: assert property (
		irq_wake && glb_en && !dev_rst |=> pc_load_o
			&& pc_vector_o == 13'h0004)
		else $error("vector not loaded on interrupt wake");
	a_wake_clears_wdt: assert property (wake_o |-> wdt_clear_o)
		else $error("wake without watchdog clear");
	a_cmp_off_mode: assert property (
		cmp_ctrl[2:0] == 3'b111 |=> !cmp_on_o)
		else $error("comparator on in off mode");
	a_reset_analog: assert property (
		dev_rst |=> cmp_ctrl == 8'h00 && vref_ctrl == 8'h00 ##1 !vref_on_o)
		else $error("reset left comparator or reference set");
	a_rc_start_delay: assert property (s_go_rc |=> s_start_late)
		else $error("rc start not delayed one instruction");
	a_sleep_abort: assert property (
		sleep_abort && !dev_rst |=> adc_abort_o && !adc_main[1]
			&& adc_main[0] ##1 !adc_power_o)
		else $error("sleep abort wrong");
	a_done_loads: assert property (
		conv_done && !dev_rst |=> result_lo == $past(adc_result_i[7:0])
			&& pflags[6] && !adc_main[1])
		else $error("completion did not load result");
	a_result_kept: assert property (
		dev_rst && !conv_done |=> result_hi === $past(result_hi)
			&& adc_state == rwic_pkg::A_IDLE)
		else $error("reset disturbed result pair");
	a_ext_edge_flag: assert property (
		ext_edge && !dev_rst |=> irq_ctrl[1])
		else $error("external edge lost");
	a_irq_needs_enable: assert property (irq_o |-> $past(glb_en))
		else $error("request without global enable");
	a_bod_clears_bit: assert property (bod_i |=> !no_bod)
		else $error("brown-out bit not cleared");
endmodule
`default_nettype wire

// *** rwic_core_model.sv ***
// Core and pin model facing the reset, wake and interrupt control.
// Assumes the bench asks for sleep and pin levels just after clk_i edges.
`timescale 1ns/10ps
`default_nettype none
module rwic_core_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Requests from the bench
	input wire logic sleep_req_i,
	input wire logic pin_req_i,
	// From the block
	input wire logic asleep_i,
	input wire logic wake_i,
	input wire logic pc_load_i,
	input wire logic wdt_clear_i,
	// To the block and the bench
	output logic sleep_exec_o,
	output logic ext_pin_o,
	output var int wakes_o,
	output var int vectors_o,
	output var int clears_o
);
	logic req_d;
	// A sleeping core fetches nothing, so no sleep while asleep
	always_ff @(posedge clk_i) begin
		req_d <= sleep_req_i;
		sleep_exec_o <= sleep_req_i & ~req_d & ~asleep_i;
		ext_pin_o <= pin_req_i;
		if (rst_i) begin
			wakes_o <= 0;
			vectors_o <= 0;
			clears_o <= 0;
		end else begin
			wakes_o <= wakes_o + int'(wake_i === 1'h1);
			vectors_o <= vectors_o + int'(pc_load_i === 1'h1);
			clears_o <= clears_o + int'(wdt_clear_i === 1'h1);
		end
	end
endmodule
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the reset, wake and interrupt control.
// Assumes rwic_pkg and the core model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic clk, rst, cyc, stb, we, erst, wrst, wwake, brownout_detect, cfg, pread;
	logic adone, slp_req, pin_req, ack, irq, wake, asleep, pcl, wdtc, eep;
	logic cmpon, vron, apow, ast, aab, slp, pin;
	logic [9:0] adr, ares;
	logic [5:0] porta, pdig;
	logic [31:0] dat, rdat;
	logic [12:0] vec;
	logic [2:0] cmode;
	logic [7:0] q;
	rwic_pkg::rwic_evt_t evt;
	int fail_count, checks_done, wakes, vecs, clrs;
	int cyc_n = 0, ack_at = 0, st_at = 0, n_abort = 0;
	rwic_ctrl DUT (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(rdat),
		.ack_o(ack), .ext_rst_i(erst), .wdt_rst_i(wrst), .wdt_wake_i(wwake),
		.bod_i(brownout_detect), .sleep_exec_i(slp), .data_protect_cfg_i(cfg),
		.irq_o(irq), .wake_o(wake), .asleep_o(asleep), .pc_load_o(pcl),
		.pc_vector_o(vec), .wdt_clear_o(wdtc), .ee_protect_o(eep),
		.ext_irq_pin_i(pin), .porta_i(porta), .port_read_i(pread),
		.evt_i(evt), .adc_done_i(adone), .adc_result_i(ares),
		.porta_dig_o(pdig), .cmp_on_o(cmpon), .cmp_mode_o(cmode),
		.vref_on_o(vron), .adc_power_o(apow), .adc_start_o(ast),
		.adc_abort_o(aab));
	rwic_core_model core (.clk_i(clk), .rst_i(rst), .sleep_req_i(slp_req),
		.pin_req_i(pin_req), .asleep_i(asleep), .wake_i(wake),
		.pc_load_i(pcl), .wdt_clear_i(wdtc), .sleep_exec_o(slp),
		.ext_pin_o(pin), .wakes_o(wakes), .vectors_o(vecs), .clears_o(clrs));
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// Latency bookkeeping for start and abort pulses
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (ack === 1'h1) ack_at <= cyc_n;
		if (ast === 1'h1) st_at <= cyc_n;
		if (aab === 1'h1) n_abort <= n_abort + 1;
	end
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Caller stands just after a rising edge; no fixed wait for ack
	task automatic bus(input logic w, input logic [7:0] ix,
		input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {ix, 2'h0};
		dat <= {24'h0, d};
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		q = rdat[7:0];
		if (n >= 20) chk("ack", 8'h1, 8'h0);
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		bus(1'h1, ix, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] ix,
		input logic [7:0] e);
		bus(1'h0, ix, 8'h0);
		chk(nm, e, q);
	endtask
	task automatic pev(input logic [3:0] e, input logic d);
		evt <= rwic_pkg::rwic_evt_t'(e);
		adone <= d;
		@(posedge clk);
		evt <= '0;
		adone <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	// k: 0 external, 1 watchdog, 2 brown-out
	task automatic rsrc(input int k);
		{brownout_detect, wrst, erst} <= 3'h1 << k;
		@(posedge clk);
		{brownout_detect, wrst, erst} <= 3'h0;
		repeat (2) @(posedge clk);
	endtask
	task automatic nap();
		slp_req <= 1'h1;
		@(posedge clk);
		slp_req <= 1'h0;
		repeat (3) @(posedge clk);
		chk("asleep", 8'h1, asleep);
	endtask
	task automatic wait_awake();
		int n;
		n = 0;
		while (asleep !== 1'h0 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk("awake", 8'h0, asleep);
	endtask
	task automatic wdt_wake();
		wwake <= 1'h1;
		@(posedge clk);
		wwake <= 1'h0;
		wait_awake();
	endtask
	task automatic t_reset();
		rdc("irq_ctrl", rwic_pkg::IDX_IRQ_CTRL, 8'h00);
		rdc("pflags", rwic_pkg::IDX_PFLAGS, 8'h00);
		rdc("cmp", rwic_pkg::IDX_CMP_CTRL, 8'h00);
		rdc("vref", rwic_pkg::IDX_VREF_CTRL, 8'h00);
		rdc("adc_main", rwic_pkg::IDX_ADC_MAIN, 8'h00);
		rdc("option", rwic_pkg::IDX_OPTION, 8'hff);
		rdc("pen", rwic_pkg::IDX_PEN, 8'h00);
		rdc("chg_en", rwic_pkg::IDX_CHG_EN, 8'h00);
		rdc("analog_sel", rwic_pkg::IDX_ANALOG_SEL, 8'hff);
		rdc("unmapped", 8'h05, 8'h00);
		rdc("status", rwic_pkg::IDX_CORE_STATUS, 8'h18);
		chk("ee_prot", 8'h1, eep);
	endtask
	task automatic t_ext();
		pin_req <= 1'h1;
		repeat (3) @(posedge clk);
		rdc("rise_flag", rwic_pkg::IDX_IRQ_CTRL, 8'h02);
		chk("irq_masked", 8'h0, irq);
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h92);
		repeat (2) @(posedge clk);
		chk("irq_on", 8'h1, irq);
		wr(rwic_pkg::IDX_OPTION, 8'hbf);
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h00);
		pin_req <= 1'h0;
		repeat (3) @(posedge clk);
		rdc("fall_flag", rwic_pkg::IDX_IRQ_CTRL, 8'h02);
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h00);
	endtask
	// Edge on the pin while asleep; ic picks global and pin enables
	task automatic t_wake(input logic [7:0] ic);
		int v0, c0, w0;
		wr(rwic_pkg::IDX_OPTION, {1'h1, ~pin_req, 6'h3f});
		wr(rwic_pkg::IDX_IRQ_CTRL, ic);
		v0 = vecs;
		c0 = clrs;
		w0 = wakes;
		nap();
		pin_req <= ~pin_req;
		repeat (6) @(posedge clk);
		chk("pin_wake", {7'h0, ~ic[4]}, asleep);
		if (!ic[4]) wdt_wake();
		wait_awake();
		chk("vector", {7'h0, ic[7] & ic[4]}, 8'(vecs - v0));
		chk("vec_addr", 8'h1, 8'(vec === 13'h0004));
		chk("wdt_clr", 8'h1, 8'(clrs - c0));
		chk("wake_pulse", 8'h1, 8'(wakes - w0));
		bus(1'h0, rwic_pkg::IDX_IRQ_CTRL, 8'h0);
		chk("irq_keep", {3'h0, ic[4:0] | 5'h02}, {3'h0, q[4:0]});
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h00);
	endtask
	task automatic t_evt();
		pev(4'h1, 1'h0);
		rdc("timer0_count_flag", rwic_pkg::IDX_IRQ_CTRL, 8'h04);
		wr(rwic_pkg::IDX_CHG_EN, 8'h01);
		porta <= 6'h02;
		repeat (3) @(posedge clk);
		rdc("chg_masked", rwic_pkg::IDX_IRQ_CTRL, 8'h04);
		porta <= 6'h03;
		repeat (3) @(posedge clk);
		rdc("chg_flag", rwic_pkg::IDX_IRQ_CTRL, 8'h05);
		// Change in the cycle of a port read is lost
		pread <= 1'h1;
		porta <= 6'h02;
		@(posedge clk);
		pread <= 1'h0;
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h00);
		rdc("chg_lost", rwic_pkg::IDX_IRQ_CTRL, 8'h00);
		pev(4'he, 1'h0);
		rdc("pflags", rwic_pkg::IDX_PFLAGS, 8'h89);
		wr(rwic_pkg::IDX_PFLAGS, 8'h00);
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h00);
	endtask
	task automatic t_cmp();
		wr(rwic_pkg::IDX_CMP_CTRL, 8'h07);
		wr(rwic_pkg::IDX_ANALOG_SEL, 8'h00);
		porta <= 6'h3f;
		repeat (2) @(posedge clk);
		chk("cmp_off", 8'h0, cmpon);
		chk("dig_all", 8'h3f, pdig);
		wr(rwic_pkg::IDX_CMP_CTRL, 8'h02);
		wr(rwic_pkg::IDX_VREF_CTRL, 8'h0f);
		chk("vref_off", 8'h0, vron);
		wr(rwic_pkg::IDX_VREF_CTRL, 8'h8f);
		chk("dig_cmp", 8'h3c, pdig);
		wr(rwic_pkg::IDX_PEN, 8'h08);
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h40);
		nap();
		chk("cmp_sleep", 8'h1, cmpon);
		chk("vref_sleep", 8'h1, vron);
		pev(4'h4, 1'h0);
		chk("cmp_wake", 8'h0, asleep);
		rdc("cmp_kept", rwic_pkg::IDX_CMP_CTRL, 8'h02);
		rdc("vref_kept", rwic_pkg::IDX_VREF_CTRL, 8'h8f);
		rsrc(0);
		chk("mode_rst", 8'h0, cmode);
		chk("vref_rst", 8'h0, vron);
		chk("dig_rst", 8'h0, pdig);
		rdc("cmp_rst", rwic_pkg::IDX_CMP_CTRL, 8'h00);
	endtask
	task automatic t_adc();
		int a0;
		wr(rwic_pkg::IDX_ADC_MAIN, 8'h03);
		repeat (2) @(posedge clk);
		chk("start_lat", 8'h1, 8'(st_at - ack_at));
		a0 = n_abort;
		nap();
		chk("abort", 8'h1, 8'(n_abort - a0));
		chk("adc_off", 8'h0, apow);
		wdt_wake();
		rdc("on_kept", rwic_pkg::IDX_ADC_MAIN, 8'h01);
		wr(rwic_pkg::IDX_ADC_CLK, 8'h30);
		wr(rwic_pkg::IDX_ADC_MAIN, 8'h03);
		a0 = n_abort;
		nap();
		chk("rc_lat", 8'h2, 8'(st_at - ack_at));
		chk("rc_run", 8'h0, 8'(n_abort - a0));
		ares <= 10'h2a5;
		pev(4'h0, 1'h1);
		chk("no_wake", 8'h1, asleep);
		chk("adc_down", 8'h0, apow);
		wdt_wake();
		rdc("go_clr", rwic_pkg::IDX_ADC_MAIN, 8'h01);
		rdc("ad_flag", rwic_pkg::IDX_PFLAGS, 8'h40);
		rdc("res_hi", rwic_pkg::IDX_RESULT_HI, 8'h02);
		rdc("res_lo", rwic_pkg::IDX_RESULT_LO, 8'ha5);
		wr(rwic_pkg::IDX_PEN, 8'h40);
		wr(rwic_pkg::IDX_IRQ_CTRL, 8'h40);
		wr(rwic_pkg::IDX_ADC_MAIN, 8'h03);
		nap();
		pev(4'h0, 1'h1);
		chk("ad_wake", 8'h0, asleep);
		wr(rwic_pkg::IDX_ADC_MAIN, 8'h03);
		rsrc(0);
		chk("adc_rst", 8'h0, apow);
		rdc("main_rst", rwic_pkg::IDX_ADC_MAIN, 8'h00);
		rdc("res_keep", rwic_pkg::IDX_RESULT_LO, 8'ha5);
	endtask
	task automatic t_rst();
		wr(rwic_pkg::IDX_RST_CAUSE, 8'h01);
		wr(rwic_pkg::IDX_OPTION, 8'h00);
		rsrc(1);
		rdc("opt_wdt", rwic_pkg::IDX_OPTION, 8'hff);
		bus(1'h0, rwic_pkg::IDX_RST_CAUSE, 8'h0);
		chk("bod_keep", 8'h1, q[0]);
		rsrc(2);
		bus(1'h0, rwic_pkg::IDX_RST_CAUSE, 8'h0);
		chk("bod_clr", 8'h0, q[0]);
		cfg <= 1'h1;
		repeat (3) @(posedge clk);
		chk("ee_open", 8'h0, eep);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Whole run is a few hundred cycles; this span is far beyond it
	initial begin
		#1000000;
		fail_count++;
		report_and_stop();
	end
	initial begin
		{rst, cyc, stb, we, erst, wrst, wwake, brownout_detect} = 8'h80;
		{cfg, pread, adone, slp_req, pin_req} = 5'h0;
		{adr, ares, porta, dat} = '0;
		evt = '0;
		fail_count = 0;
		checks_done = 0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		t_reset();
		t_ext();
		t_wake(8'h90);
		t_wake(8'h10);
		t_wake(8'h80);
		t_evt();
		t_cmp();
		t_adc();
		t_rst();
		report_and_stop();
	end
endmodule
`default_nettype wire
